// ===== tb/testbench.sv
// self-checking bench for the udp frame packetizer
`timescale 1ns/10ps
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic in_valid = 1'b0;
	ufp_pkg::ufp_beat_t in_beat = '0;
	logic [31:0] frame_total = '0;
	logic [31:0] flags = '0;
	ufp_pkg::ufp_net_cfg_t net_cfg = '0;
	logic slow = 1'b0;
	logic out_ready, in_ready, out_valid, got;
	ufp_pkg::ufp_beat_t out_beat, rx_beat;
	logic [31:0] dest_ip;
	logic [15:0] dest_port;
	logic [47:0] rx_dest;
	ufp_pkg::ufp_beat_t exp_q[$]; // bytes still to come
	logic [47:0] dest_q[$]; // one destination per datagram
	logic [7:0] pay[$]; // payload of the open datagram
	logic [15:0] fseq = '0;
	logic [31:0] tot, flg;
	logic [47:0] dst;
	int pos = 0;
	int mismatches = 0;
	int cmp_count = 0;

	always #2 clk = ~clk;

	ufp_packetizer i_ufp_packetizer (.i_clk(clk), .i_reset_n(reset_n),
		.i_in_valid(in_valid), .i_in_beat(in_beat),
		.i_frame_total(frame_total), .i_flags(flags), .i_net_cfg(net_cfg),
		.i_out_ready(out_ready), .o_in_ready(in_ready),
		.o_out_valid(out_valid), .o_out_beat(out_beat),
		.o_dest_ip(dest_ip), .o_dest_port(dest_port));

	ufp_rx_model i_ufp_rx_model (.i_clk(clk), .i_reset_n(reset_n),
		.i_slow(slow), .i_valid(out_valid), .i_beat(out_beat),
		.i_dest({dest_ip, dest_port}), .o_ready(out_ready), .o_got(got),
		.o_beat(rx_beat), .o_dest(rx_dest));

	// ----------------------------------------
	// compare and report
	// ----------------------------------------
	task automatic cmp_beat(input ufp_pkg::ufp_beat_t e, s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value datagram byte expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_dest(input logic [47:0] e, s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value destination expected %h seen %h", e, s);
		end
	endtask

	task automatic cmp_flag(input logic e, s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value input ready expected %h seen %h", e, s);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// msb-first crc step, no reflection
	function automatic logic [31:0] crc_add(logic [31:0] c, logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i]) ? ufp_pkg::CRC_POLY : '0);
		end
		return c;
	endfunction

	// ----------------------------------------
	// expected datagram builder
	// ----------------------------------------
	task automatic note_pkt(input logic [15:0] pidx);
		logic [7:0] h[32];
		logic [31:0] c;
		h = '{default: 8'h00};
		{h[0], h[1]} = ufp_pkg::PROTO_VERSION;
		{h[2], h[3]} = fseq;
		{h[4], h[5]} = pidx;
		{h[6], h[7]} = 16'(pay.size());
		{h[8], h[9], h[10], h[11]} = tot;
		{h[16], h[17], h[18], h[19]} = flg;
		c = ufp_pkg::CRC_INIT;
		foreach (h[i]) c = crc_add(c, h[i]);
		foreach (pay[i]) c = crc_add(c, pay[i]);
		{h[12], h[13], h[14], h[15]} = c;
		foreach (h[i]) exp_q.push_back(ufp_pkg::ufp_beat_t'{h[i], 1'b0});
		foreach (pay[i])
			exp_q.push_back(ufp_pkg::ufp_beat_t'{pay[i], i == pay.size() - 1});
		dest_q.push_back(dst);
		pay.delete();
	endtask

	// drives one frame and notes every datagram it makes
	task automatic send_frame(input int n);
		int k;
		logic [15:0] p;
		p = '0;
		tot = n;
		flg = $urandom;
		dst = net_cfg.use_custom ? {net_cfg.ip, net_cfg.port} :
			{ufp_pkg::DEF_DEST_IP, ufp_pkg::DEF_DEST_PORT};
		frame_total = tot;
		flags = flg;
		for (int b = 0; b < n; b++) begin
			in_valid = 1'b1;
			in_beat = '{8'($urandom), b == n - 1};
			k = 0;
			while (in_ready !== 1'b1) begin
				@(posedge clk);
				#1;
				k++;
				if (k > 20000) begin
					mismatches++;
					finish_test();
				end
			end
			@(posedge clk);
			#1;
			pay.push_back(in_beat.data);
			if (pay.size() == ufp_pkg::MAX_DATA_N || in_beat.last) begin
				note_pkt(p);
				p++;
			end
		end
		in_valid = 1'b0;
		fseq++;
		// let an edge pass before the next frame raises valid again
		@(posedge clk);
		#1;
	endtask

	// waits until every noted byte has been seen
	task automatic drain(input string name);
		for (int k = 0; exp_q.size() != 0; k++) begin
			@(posedge clk);
			#1;
			if (k > 30000) begin
				mismatches++;
				finish_test();
			end
		end
		$display("test %s done, mismatches %0d", name, mismatches);
	endtask

	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	always @(posedge clk) begin
		if (got) begin
			if (pos == 0)
				cmp_dest(dest_q.size() ? dest_q.pop_front() : 'x, rx_dest);
			cmp_beat(exp_q.size() ? exp_q.pop_front() : 'x, rx_beat);
			pos = rx_beat.last ? 0 : pos + 1;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic seen;
		void'($urandom(29001));
		repeat (10) @(posedge clk);
		#1;
		reset_n = 1'b1;
		// two datagrams, the second a single byte
		send_frame(1401);
		drain("split frame");
		// custom destination, one full datagram, slow client
		slow = 1'b1;
		net_cfg = '{1'b0, 1'b1, 32'($urandom), 16'($urandom)};
		send_frame(1400);
		drain("custom destination");
		// streaming switched off at a frame boundary
		net_cfg.stream_off = 1'b1;
		repeat (4) @(posedge clk);
		seen = 1'b0;
		repeat (40) begin
			@(posedge clk);
			#1;
			seen = seen | in_ready;
		end
		cmp_flag(1'b0, seen);
		net_cfg.stream_off = 1'b0;
		drain("stream off");
		// random frame lengths, default and custom destinations
		for (int f = 0; f < 3; f++) begin
			slow = f[0];
			net_cfg.use_custom = f[1];
			send_frame(1 + $urandom_range(2999));
		end
		drain("random frames");
		finish_test();
	end
endmodule

// ===== tb/ufp_rx_model.sv
// receiving client model that takes the datagram byte stream
`timescale 1ns/10ps
module ufp_rx_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire ufp_pkg::ufp_beat_t i_beat,
	input wire logic [47:0] i_dest,
	output logic o_ready,
	output logic o_got,
	output ufp_pkg::ufp_beat_t o_beat,
	output logic [47:0] o_dest
);
	logic [7:0] lfsr_q; // stall pattern source
	// ----------------------------------------
	// accept side
	// ----------------------------------------
	// takes each byte offered while o_ready is high and records its destination
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lfsr_q <= 8'hA5;
			o_ready <= 1'b0;
			o_got <= 1'b0;
		end else begin
			lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[3]};
			o_ready <= !i_slow || lfsr_q[0]; // slow mode stalls often
			o_got <= i_valid && o_ready; // one pulse per byte taken
			o_beat <= i_beat;
			o_dest <= i_dest;
		end
	end
endmodule

// ===== verilog/ufp_crc32_step.sv
// one-byte step of the msb-first crc-32
`timescale 1ns/10ps
module ufp_crc32_step (
	input wire logic [31:0] i_crc,
	input wire logic [7:0] i_byte,
	output logic [31:0] o_crc
);

	// ------------------------------------------------------------
	// shift eight bits, msb first
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] c;
		logic fb;
		c = i_crc;
		fb = 1'b0;
		for (int k = 7; k >= 0; k--) begin
			fb = c[31] ^ i_byte[k];
			c = {c[30:0], 1'b0} ^ (fb ? ufp_pkg::CRC_POLY : 32'h00000000);
		end
		o_crc = c;
	end

endmodule

// ===== verilog/ufp_packetizer.sv
// frame byte stream to udp streaming datagrams
// What this block does
// - 32-byte header, then at most 1400 bytes
// - datagrams at most 1432 bytes, last may be shorter
// - version 0x0001 msb first at offset 0
// - frame count at 0x02, wraps after maximum
// - packet index at 0x04, receiver orders by it
// - payload byte count at 0x06
// - frame byte total at 0x08, 32 bits
// - crc-32 of whole datagram at 0x0C
// - flags at 0x10, 0x14-0x1F reserved, data 0x20
// - streaming on without any configuration
// - default destination 224.0.0.1 port 10002
// - configuration registers override destination
`timescale 1ns/10ps
module ufp_packetizer (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_in_valid,
	input wire ufp_pkg::ufp_beat_t i_in_beat,
	input wire logic [31:0] i_frame_total,
	input wire logic [31:0] i_flags,
	input wire ufp_pkg::ufp_net_cfg_t i_net_cfg,
	input wire logic i_out_ready,
	output logic o_in_ready,
	output logic o_out_valid,
	output ufp_pkg::ufp_beat_t o_out_beat,
	output logic [31:0] o_dest_ip,
	output logic [15:0] o_dest_port
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ufp_pkg::ufp_state_t st_q; // registered state
	ufp_pkg::ufp_state_t st_d; // next state
	logic take; // input byte accepted
	logic adv; // output register may load
	logic [10:0] tot; // datagram length in bytes
	logic [10:0] data_off; // payload slot of idx
	logic [0:ufp_pkg::HDR_N-1][7:0] hdr; // header image
	logic [7:0] cur_byte; // datagram byte at idx
	logic [31:0] crc_step; // crc after cur_byte
	logic fin; // datagram fully handed on

	// ------------------------------------------------------------
	// checksum engine
	// ------------------------------------------------------------
	ufp_crc32_step u_crc (
		.i_crc(st_q.crc),
		.i_byte(cur_byte),
		.o_crc(crc_step)
	);

	// ------------------------------------------------------------
	// header image and byte selection
	// ------------------------------------------------------------
	always_comb begin
		hdr = '0;
		hdr[ufp_pkg::OFS_VERSION +: 2] = ufp_pkg::PROTO_VERSION;
		hdr[ufp_pkg::OFS_FSEQ +: 2] = st_q.fseq;
		hdr[ufp_pkg::OFS_PIDX +: 2] = st_q.pidx;
		hdr[ufp_pkg::OFS_PLEN +: 2] = {5'h00, st_q.cnt};
		hdr[ufp_pkg::OFS_TOTAL +: 4] = st_q.total;
		// crc reads as zero while it is computed
		hdr[ufp_pkg::OFS_CRC +: 4] =
			(st_q.fsm == ufp_pkg::ST_SEND) ? st_q.crc : 32'h00000000;
		hdr[ufp_pkg::OFS_FLAGS +: 4] = st_q.flags;
		hdr[ufp_pkg::OFS_RSVD +: ufp_pkg::RSVD_N] = '0;
	end

	assign tot = st_q.cnt + ufp_pkg::HDR_LEN;
	assign data_off = st_q.idx - ufp_pkg::OFS_DATA;
	assign cur_byte = (st_q.idx < ufp_pkg::OFS_DATA) ?
		hdr[st_q.idx[4:0]] : st_q.store[data_off];

	// handshake terms
	assign take = i_in_valid & st_q.in_ready;
	assign adv = ~st_q.out_valid | i_out_ready;
	assign fin = (st_q.fsm == ufp_pkg::ST_SEND) & adv & (st_q.idx == tot);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		unique case (st_q.fsm)
			// gather payload of one datagram
			ufp_pkg::ST_COLLECT: begin
				if (take) begin
					st_d.store[st_q.cnt] = i_in_beat.data;
					st_d.cnt = st_q.cnt + 11'h001;
					// first byte of a frame latches its totals
					if (!st_q.mid) begin
						st_d.mid = 1'b1;
						st_d.total = i_frame_total;
						st_d.flags = i_flags;
					end
					// close at 1400 bytes or frame end
					if (i_in_beat.last || st_q.cnt == ufp_pkg::LAST_SLOT) begin
						st_d.fsm = ufp_pkg::ST_CRC;
						st_d.idx = 11'h000;
						st_d.crc = ufp_pkg::CRC_INIT;
						st_d.fend = i_in_beat.last;
						if (i_net_cfg.use_custom) begin
							st_d.dest_ip = i_net_cfg.ip;
							st_d.dest_port = i_net_cfg.port;
						end else begin
							st_d.dest_ip = ufp_pkg::DEF_DEST_IP;
							st_d.dest_port = ufp_pkg::DEF_DEST_PORT;
						end
					end
				end
			end
			// checksum pass over the whole datagram
			ufp_pkg::ST_CRC: begin
				st_d.crc = crc_step;
				st_d.idx = st_q.idx + 11'h001;
				if (st_q.idx == tot - 11'h001) begin
					st_d.fsm = ufp_pkg::ST_SEND;
					st_d.idx = 11'h000;
				end
			end
			// hand bytes to the network side
			ufp_pkg::ST_SEND: begin
				if (adv) begin
					if (st_q.idx < tot) begin
						st_d.out_valid = 1'b1;
						st_d.out_beat.data = cur_byte;
						st_d.out_beat.last = (st_q.idx == tot - 11'h001);
						st_d.idx = st_q.idx + 11'h001;
					end else begin
						st_d.out_valid = 1'b0;
						st_d.fsm = ufp_pkg::ST_COLLECT;
						st_d.cnt = 11'h000;
						if (st_q.fend) begin
							st_d.fseq = st_q.fseq + 16'h0001;
							// next frame starts at index zero
							st_d.pidx = 16'h0000;
							st_d.mid = 1'b0;
						end else begin
							st_d.pidx = st_q.pidx + 16'h0001;
						end
					end
				end
			end
		endcase
		// ready only while collecting; stream_off holds it low between frames only
		st_d.in_ready = (st_d.fsm == ufp_pkg::ST_COLLECT) &
			(st_d.mid | ~i_net_cfg.stream_off);
		// position of the byte leaving the output
		if (st_q.out_valid && i_out_ready) begin
			st_d.pos = st_q.out_beat.last ? 11'h000 : st_q.pos + 11'h001;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= '0;
			st_q.fsm <= ufp_pkg::ST_COLLECT;
			st_q.dest_ip <= ufp_pkg::DEF_DEST_IP;
			st_q.dest_port <= ufp_pkg::DEF_DEST_PORT;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs straight from the state register
	assign o_in_ready = st_q.in_ready;
	assign o_out_valid = st_q.out_valid;
	assign o_out_beat = st_q.out_beat;
	assign o_dest_ip = st_q.dest_ip;
	assign o_dest_port = st_q.dest_port;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	payload_bound_a: assert property (st_q.cnt <= ufp_pkg::MAX_DATA)
		else $error("payload count above limit");
	pkt_bound_a: assert property (
		o_out_valid && o_out_beat.last |-> st_q.pos < ufp_pkg::MAX_PKT)
		else $error("datagram longer than 1432 bytes");
	version_bytes_a: assert property (
		o_out_valid && st_q.pos == 11'h000 ##1 o_out_valid &&
		st_q.pos == 11'h001 |-> o_out_beat.data == 8'h01)
		else $error("version low byte wrong");
	// frame count advances once per frame
	frame_count_a: assert property (
		fin && st_q.fend |=> st_q.fseq == $past(st_q.fseq) + 16'h0001)
		else $error("frame count did not advance");
	pidx_field_a: assert property (
		o_out_valid && st_q.pos == 11'h005 |-> o_out_beat.data == st_q.pidx[7:0])
		else $error("packet index byte wrong");
	plen_field_a: assert property (
		o_out_valid && st_q.pos == 11'h007 |-> o_out_beat.data == st_q.cnt[7:0])
		else $error("payload length byte wrong");
	total_field_a: assert property (
		o_out_valid && st_q.pos == 11'h008 |->
		o_out_beat.data == st_q.total[31:24])
		else $error("frame total byte wrong");
	// crc starts from its seed and lands in the header
	crc_seed_a: assert property (
		$past(st_q.fsm) == ufp_pkg::ST_COLLECT && st_q.fsm == ufp_pkg::ST_CRC
		|-> st_q.crc == ufp_pkg::CRC_INIT)
		else $error("crc seed wrong");
	crc_field_a: assert property (
		o_out_valid && st_q.pos == 11'h00C |-> o_out_beat.data == st_q.crc[31:24])
		else $error("crc byte wrong");
	rsvd_zero_a: assert property (
		o_out_valid && st_q.pos >= 11'h014 && st_q.pos < ufp_pkg::OFS_DATA
		|-> o_out_beat.data == 8'h00)
		else $error("reserved byte not zero");
	// ready returns while streaming is on
	stream_on_a: assert property (
		st_q.fsm == ufp_pkg::ST_COLLECT && !o_in_ready && !i_net_cfg.stream_off
		|=> o_in_ready)
		else $error("input not ready with streaming on");
	dest_default_a: assert property (
		$past(st_q.fsm) == ufp_pkg::ST_COLLECT && st_q.fsm == ufp_pkg::ST_CRC &&
		!$past(i_net_cfg.use_custom) |-> o_dest_ip == ufp_pkg::DEF_DEST_IP &&
		o_dest_port == ufp_pkg::DEF_DEST_PORT)
		else $error("default destination wrong");
	dest_custom_a: assert property (
		$past(st_q.fsm) == ufp_pkg::ST_COLLECT && st_q.fsm == ufp_pkg::ST_CRC &&
		$past(i_net_cfg.use_custom) |-> o_dest_ip == $past(i_net_cfg.ip) &&
		o_dest_port == $past(i_net_cfg.port))
		else $error("configured destination ignored");
	// index restarts per frame, else counts up
	pidx_step_a: assert property (
		fin |=> st_q.pidx ==
		($past(st_q.fend) ? 16'h0000 : $past(st_q.pidx) + 16'h0001))
		else $error("packet index step wrong");
	// only the closing datagram may be short
	short_last_a: assert property (
		o_out_valid && o_out_beat.last && !st_q.fend |->
		st_q.pos == ufp_pkg::MAX_PKT - 11'h001)
		else $error("datagram short before frame end");
	out_hold_a: assert property (
		o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_beat))
		else $error("output byte changed while stalled");
	// no input taken while a datagram is out
	in_stall_a: assert property (
		st_q.fsm != ufp_pkg::ST_COLLECT |-> !o_in_ready)
		else $error("input ready outside collection");
	// destination fixed for the whole datagram
	dest_stable_a: assert property (
		st_q.fsm != ufp_pkg::ST_COLLECT &&
		$past(st_q.fsm) != ufp_pkg::ST_COLLECT |->
		$stable(o_dest_ip) && $stable(o_dest_port))
		else $error("destination changed inside datagram");
	// first payload byte after the header
	data_start_a: assert property (
		o_out_valid && st_q.pos == ufp_pkg::OFS_DATA |->
		o_out_beat.data == st_q.store[0])
		else $error("payload does not follow header");
	fseq_field_a: assert property (
		o_out_valid && st_q.pos == 11'h002 |-> o_out_beat.data == st_q.fseq[15:8])
		else $error("frame count byte wrong");
	flags_field_a: assert property (
		o_out_valid && st_q.pos == 11'h013 |-> o_out_beat.data == st_q.flags[7:0])
		else $error("flags byte wrong");
	version_hi_a: assert property (
		o_out_valid && st_q.pos == 11'h000 |-> o_out_beat.data == 8'h00)
		else $error("version high byte wrong");
	// crc low byte closes the field
	crc_low_a: assert property (
		o_out_valid && st_q.pos == 11'h00F |-> o_out_beat.data == st_q.crc[7:0])
		else $error("crc low byte wrong");

	// main scenarios
	full_pkt_c: cover property (o_out_valid && o_out_beat.last &&
		st_q.pos == ufp_pkg::MAX_PKT - 11'h001);
	frame_end_c: cover property (fin && st_q.fend);
	backpressure_c: cover property (o_out_valid && !i_out_ready);
	custom_dest_c: cover property (st_q.fsm == ufp_pkg::ST_CRC &&
		o_dest_ip != ufp_pkg::DEF_DEST_IP);
	stream_off_c: cover property (st_q.fsm == ufp_pkg::ST_COLLECT &&
		!st_q.mid && i_net_cfg.stream_off && !o_in_ready);

endmodule

// ===== verilog/ufp_pkg.sv
// constants, types and states shared by the udp frame packetizer
package ufp_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int unsigned MAX_DATA_N = 1400; // data bytes per datagram
	localparam int unsigned HDR_N = 32; // header bytes
	localparam logic [10:0] HDR_LEN = 11'h020; // header length, 32
	localparam logic [10:0] MAX_DATA = 11'h578; // 1400 data bytes
	localparam logic [10:0] MAX_PKT = 11'h598; // 1432 bytes per datagram
	localparam logic [10:0] LAST_SLOT = MAX_DATA - 11'h001; // last data slot

	// ------------------------------------------------------------
	// header field offsets
	// ------------------------------------------------------------
	localparam int unsigned OFS_VERSION = 32'h00000000; // protocol version
	localparam int unsigned OFS_FSEQ = 32'h00000002; // frame sequence count
	localparam int unsigned OFS_PIDX = 32'h00000004; // packet index
	localparam int unsigned OFS_PLEN = 32'h00000006; // payload byte count
	localparam int unsigned OFS_TOTAL = 32'h00000008; // frame byte total
	localparam int unsigned OFS_CRC = 32'h0000000C; // packet checksum
	localparam int unsigned OFS_FLAGS = 32'h00000010; // flags word
	localparam int unsigned OFS_RSVD = 32'h00000014; // reserved, reads zero
	localparam int unsigned RSVD_N = 32'h0000000C; // reserved byte count
	localparam logic [10:0] OFS_DATA = 11'h020; // frame data section

	// ------------------------------------------------------------
	// field values
	// ------------------------------------------------------------
	localparam logic [15:0] PROTO_VERSION = 16'h0001; // version code
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7; // crc generator
	localparam logic [31:0] CRC_INIT = 32'h0FFFFFFF; // crc start value
	localparam logic [31:0] DEF_DEST_IP = 32'hE0000001; // 224.0.0.1
	localparam logic [15:0] DEF_DEST_PORT = 16'h2712; // port 10002

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	// one byte of a stream with its end marker
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} ufp_beat_t;

	// settings from the network configuration register group
	typedef struct packed {
		logic stream_off; // zero keeps streaming on
		logic use_custom; // take ip and port below
		logic [31:0] ip;
		logic [15:0] port;
	} ufp_net_cfg_t;

	// packetizer phases
	typedef enum logic [2:0] {
		ST_COLLECT = 3'b001,
		ST_CRC = 3'b010,
		ST_SEND = 3'b100
	} ufp_fsm_t;

	// whole state of the packetizer
	typedef struct packed {
		ufp_fsm_t fsm;
		logic [MAX_DATA_N-1:0][7:0] store; // payload of one datagram
		logic [10:0] cnt; // payload bytes held
		logic [10:0] idx; // datagram byte pointer
		logic [31:0] crc;
		logic [15:0] fseq;
		logic [15:0] pidx;
		logic [31:0] total;
		logic [31:0] flags;
		logic mid; // frame under way
		logic fend; // datagram closes its frame
		logic in_ready;
		logic out_valid;
		ufp_beat_t out_beat;
		logic [31:0] dest_ip;
		logic [15:0] dest_port;
		logic [10:0] pos; // output byte position
	} ufp_state_t;

endpackage
